/* verilog/mpwm_pkg.sv */
package mpwm_pkg;
    // Register byte offsets
    localparam logic [7:0] MPWM_CTRL_OFS      = 8'h00;
    localparam logic [7:0] MPWM_MODULUS_OFS   = 8'h04;
    localparam logic [7:0] MPWM_DUTY1_OFS     = 8'h08;
    localparam logic [7:0] MPWM_DUTY2_OFS     = 8'h0C;
    localparam logic [7:0] MPWM_DUTY3_OFS     = 8'h10;
    localparam logic [7:0] MPWM_DEADTIME_OFS  = 8'h14;
    localparam logic [7:0] MPWM_DISABLE_PIN_MAP_OFS    = 8'h18;
    localparam logic [7:0] MPWM_FCTRL_OFS     = 8'h1C;
    localparam logic [7:0] MPWM_FSTATUS_OFS   = 8'h20;
    localparam logic [7:0] MPWM_FACK_OFS      = 8'h24;
    localparam logic [7:0] MPWM_MANUAL_OFS    = 8'h28;
    // Register field bit positions
    localparam int MPWM_CTRL_RUN     = 0;
    localparam int MPWM_CTRL_CENTER  = 1;
    localparam int MPWM_CTRL_INDEP   = 2;
    localparam int MPWM_CTRL_LOADOK  = 3;
    localparam int MPWM_CTRL_LDFQ_LO = 4;
    localparam int MPWM_FCTRL_SWDIS  = 4;
    localparam int MPWM_MAN_ENABLE   = 7;
    localparam int MPWM_FACK_DT_LO   = 4;
    // Reset values
    localparam logic [11:0] MPWM_MODULUS_RST = 12'h0FF;
    localparam logic [7:0]  MPWM_ZERO8       = 8'h00;

    typedef enum logic [1:0] {
        MPWM_LD_EVERY1,
        MPWM_LD_EVERY2,
        MPWM_LD_EVERY4,
        MPWM_LD_EVERY8
    } mpwm_ldfq_t;

    typedef struct packed {
        logic [3:0] level;
        logic [3:0] flag;
    } mpwm_fault_t;
endpackage

/* verilog/mpwm_fault_out.sv */
`timescale 1ns/100ps
// How it works
// R1: Rising fault edge sets flag within three cycles
// R2: Fault status register ignores all writes
// R3: Level bit mirrors present fault pin level
// R4: Flag stays until acknowledge one clears it
// R5: Acknowledge bits always read back zero
// R6: Sense input one sampled ending dead time
// R7: Sense two for outputs 3,4; three 5,6
// R8: Manual enable feeds output stage manual bits
// R9: Generator keeps running during manual control
// R10: Clearing manual enable returns generator path immediately
// R11: Odd manual bit drives its output directly
// R12: Complementary even bit drives its output only while partner bit is clear
// R13: Independent even bit drives own output directly
// R14: Center-aligned period is twice the modulus
// R15: Edge-aligned period equals modulus ticks
// R16: Parameters load only at load-cycle boundaries
// R17: Fault disable acts regardless of interrupt enable
// R18: Fault disables outputs selected by write-once map
// R19: Interrupt requested only when enabled and flagged
// R20: Reload every 1, 2, 4 or 8 periods
// R21: Fault set wins over simultaneous acknowledge
// R22: Reset clears flags, sense, manual bits
// R23: Fault inputs synchronised before edge detection
module mpwm_fault_out
    import mpwm_pkg::*;
#(
    parameter int CW = 12
) (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // Power stage pins
    input  wire logic [3:0]    fault_in,
    input  wire logic [2:0]    current_sense_in,
    output logic [5:0]         pwm_out,
    // Fault interrupt request
    output logic               fault_irq_req
);
    logic [3:0]    fs1, fs2, fs3;
    logic [2:0]    is1, is2, is3;
    logic [3:0]    fault_event_flag;
    logic [3:0]    fault_irq_enable;
    logic          soft_disable;
    logic [5:0]    deadtime_sense_status;
    logic          manual_override_enable;
    logic [5:0]    manual_pin_values;
    logic [7:0]    deadtime, disable_pin_map;
    logic          deadtime_written, disable_pin_map_written;
    logic          run, center, indep, load_ok;
    logic [1:0]    reload_rate_select, act_ldfq;
    logic [CW-1:0] mod_buf, act_mod;
    logic [CW-1:0] duty_buf [3];
    logic [CW-1:0] act_duty [3];
    logic [CW-1:0] cnt;
    logic          count_down, period_end;
    logic [2:0]    period_cnt;
    logic [2:0]    gen_pair;
    logic [5:0]    stage_req;
    logic [5:0]    req_d;
    logic [7:0]    dt_cnt [6];
    logic [5:0]    disabled;
    logic          wr, rd;
    logic [3:0]    ack;
    mpwm_fault_t   fstat;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !pwrite;
    assign ack = (wr && paddr == MPWM_FACK_OFS) ? pwdata[3:0] : 4'h0;
    assign pready = 1'b1;
    assign fstat.level = fs3;                                          // R3
    assign fstat.flag = fault_event_flag;

    function automatic logic [2:0] reload_span(input logic [1:0] code);
        case (mpwm_ldfq_t'(code))                                      // R20
            MPWM_LD_EVERY1: reload_span = 3'h0;
            MPWM_LD_EVERY2: reload_span = 3'h1;
            MPWM_LD_EVERY4: reload_span = 3'h3;
            MPWM_LD_EVERY8: reload_span = 3'h7;
            default:        reload_span = 3'h0;
        endcase
    endfunction

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs1 <= 4'h0;
            fs2 <= 4'h0;
            fs3 <= 4'h0;
            is1 <= 3'h0;
            is2 <= 3'h0;
            is3 <= 3'h0;
        end else begin
            fs1 <= fault_in;                                           // R23
            fs2 <= fs1;
            fs3 <= fs2;
            is1 <= current_sense_in;
            is2 <= is1;
            is3 <= is2;
        end
    end

    // Edge seen at stage two to meet the three-cycle flag latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_event_flag <= 4'h0;                                  // R22
        end else begin
            fault_event_flag <= (fault_event_flag & ~ack) | (fs2 & ~fs3); // R1 R4 R21
        end
    end

    assign fault_irq_req = |(fault_event_flag & fault_irq_enable);     // R19

    // Register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run                    <= 1'b0;
            center                 <= 1'b0;
            indep                  <= 1'b0;
            reload_rate_select     <= 2'h0;
            mod_buf                <= MPWM_MODULUS_RST;
            duty_buf[0]            <= '0;
            duty_buf[1]            <= '0;
            duty_buf[2]            <= '0;
            deadtime               <= MPWM_ZERO8;
            disable_pin_map        <= MPWM_ZERO8;
            deadtime_written       <= 1'b0;
            disable_pin_map_written         <= 1'b0;
            fault_irq_enable       <= 4'h0;
            soft_disable           <= 1'b0;
            manual_override_enable <= 1'b0;                            // R22
            manual_pin_values      <= 6'h00;
        end else if (wr) begin
            case (paddr)
                MPWM_CTRL_OFS: begin
                    run                <= pwdata[MPWM_CTRL_RUN];
                    center             <= pwdata[MPWM_CTRL_CENTER];
                    indep              <= pwdata[MPWM_CTRL_INDEP];
                    reload_rate_select <= pwdata[MPWM_CTRL_LDFQ_LO +: 2];
                end
                MPWM_MODULUS_OFS: mod_buf <= pwdata[CW-1:0];
                MPWM_DUTY1_OFS:   duty_buf[0] <= pwdata[CW-1:0];
                MPWM_DUTY2_OFS:   duty_buf[1] <= pwdata[CW-1:0];
                MPWM_DUTY3_OFS:   duty_buf[2] <= pwdata[CW-1:0];
                MPWM_DEADTIME_OFS: begin
                    if (!deadtime_written) begin
                        deadtime         <= pwdata[7:0];
                        deadtime_written <= 1'b1;
                    end
                end
                MPWM_DISABLE_PIN_MAP_OFS: begin
                    if (!disable_pin_map_written) begin
                        disable_pin_map <= pwdata[7:0];
                        disable_pin_map_written  <= 1'b1;
                    end
                end
                MPWM_FCTRL_OFS: begin
                    fault_irq_enable <= pwdata[3:0];
                    soft_disable     <= pwdata[MPWM_FCTRL_SWDIS];
                end
                MPWM_MANUAL_OFS: begin
                    manual_override_enable <= pwdata[MPWM_MAN_ENABLE];
                    manual_pin_values      <= pwdata[5:0];
                end
                default: ;                                             // R2
            endcase
        end
    end

    // Read mux and error answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                case (paddr)
                    MPWM_CTRL_OFS: prdata[5:0] <= {reload_rate_select, load_ok,
                                                   indep, center, run};
                    MPWM_MODULUS_OFS: prdata[CW-1:0] <= mod_buf;
                    MPWM_DUTY1_OFS:   prdata[CW-1:0] <= duty_buf[0];
                    MPWM_DUTY2_OFS:   prdata[CW-1:0] <= duty_buf[1];
                    MPWM_DUTY3_OFS:   prdata[CW-1:0] <= duty_buf[2];
                    MPWM_DEADTIME_OFS: prdata[7:0] <= deadtime;
                    MPWM_DISABLE_PIN_MAP_OFS:   prdata[7:0] <= disable_pin_map;
                    MPWM_FCTRL_OFS:    prdata[4:0] <= {soft_disable, fault_irq_enable};
                    MPWM_FSTATUS_OFS:  prdata[7:0] <= fstat;
                    // Acknowledge bits stay zero
                    MPWM_FACK_OFS: prdata[MPWM_FACK_DT_LO +: 6] <= deadtime_sense_status; // R5
                    MPWM_MANUAL_OFS: prdata[7:0] <= {manual_override_enable, 1'b0,
                                                     manual_pin_values};
                    default: pslverr <= 1'b1;
                endcase
            end else if (psel && penable) begin
                pslverr <= pslverr;
                prdata  <= prdata;
            end
        end
    end

    // Period counter; keeps running under manual control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt        <= '0;
            count_down <= 1'b0;
        end else if (run) begin                                        // R9
            if (!center) begin
                cnt        <= (cnt >= act_mod - 1'b1) ? '0 : cnt + 1'b1; // R15
                count_down <= 1'b0;
            end else if (!count_down) begin
                cnt        <= cnt + 1'b1;                              // R14
                count_down <= (cnt + 1'b1 >= act_mod);
            end else begin
                cnt        <= cnt - 1'b1;
                count_down <= (cnt > 1);
            end
        end
    end

    assign period_end = run && (center ? (count_down && cnt == 1)
                                       : (cnt >= act_mod - 1'b1));

    // Load cycle: buffered values take effect only at its boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_cnt  <= 3'h0;
            load_ok     <= 1'b0;
            act_ldfq    <= 2'h0;
            act_mod     <= MPWM_MODULUS_RST;
            act_duty[0] <= '0;
            act_duty[1] <= '0;
            act_duty[2] <= '0;
        end else begin
            if (wr && paddr == MPWM_CTRL_OFS && pwdata[MPWM_CTRL_LOADOK])
                load_ok <= 1'b1;
            if (period_end) begin
                if (period_cnt >= reload_span(act_ldfq)) begin
                    period_cnt <= 3'h0;
                    act_ldfq   <= reload_rate_select;                  // R16
                    if (load_ok) begin
                        act_mod  <= mod_buf;
                        act_duty <= duty_buf;
                        load_ok  <= 1'b0;
                    end
                end else begin
                    period_cnt <= period_cnt + 3'h1;
                end
            end
        end
    end

    always_comb begin
        for (int p = 0; p < 3; p++)
            gen_pair[p] = run && (cnt < act_duty[p]);
    end

    // Source select: manual bits or generator, switched without delay
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            if (manual_override_enable) begin                          // R8 R10
                stage_req[2*p]   = manual_pin_values[2*p];             // R11
                stage_req[2*p+1] = indep ? manual_pin_values[2*p+1]    // R13
                                 : (manual_pin_values[2*p+1] && !manual_pin_values[2*p]); // R12
            end else begin
                stage_req[2*p]   = gen_pair[p];
                stage_req[2*p+1] = indep ? gen_pair[p] : !gen_pair[p];
            end
        end
    end

    // Fault or software disable, independent of interrupt enables
    assign disabled = disable_pin_map[5:0] & {6{(|fault_event_flag) || soft_disable}}; // R17 R18

    // Dead-time stage with current-sense sampling at its end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_d                 <= 6'h00;
            pwm_out               <= 6'h00;
            deadtime_sense_status <= 6'h00;                            // R22
            for (int i = 0; i < 6; i++)
                dt_cnt[i] <= MPWM_ZERO8;
        end else begin
            req_d <= stage_req;
            for (int i = 0; i < 6; i++) begin
                if (stage_req[i] && !req_d[i] && !indep && deadtime != 0) begin
                    dt_cnt[i]  <= deadtime;
                    pwm_out[i] <= 1'b0;
                end else if (stage_req[i] && dt_cnt[i] > 1) begin
                    dt_cnt[i]  <= dt_cnt[i] - 8'h01;
                    pwm_out[i] <= 1'b0;
                end else begin
                    if (stage_req[i] && dt_cnt[i] == 1)
                        deadtime_sense_status[i] <= is3[i/2];          // R6 R7
                    dt_cnt[i]  <= MPWM_ZERO8;
                    pwm_out[i] <= stage_req[i] && !disabled[i];
                end
            end
        end
    end

    // Checks
    a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn) // R1
        (fs2 & ~fs3) != 4'h0 |=> (fault_event_flag & $past(fs2 & ~fs3)) == $past(fs2 & ~fs3))
        else $error("fault flag not set after rising edge");
    a_status_readonly: assert property (@(posedge pclk) disable iff (!presetn) // R2
        wr && paddr == MPWM_FSTATUS_OFS && (fs2 & ~fs3) == 4'h0
        |=> fault_event_flag == $past(fault_event_flag))
        else $error("status write changed a flag");
    a_level_mirror: assert property (@(posedge pclk) disable iff (!presetn) // R3
        rd && !penable && paddr == MPWM_FSTATUS_OFS |=> prdata[7:4] == $past(fs3))
        else $error("pin level read wrong");
    a_flag_holds: assert property (@(posedge pclk) disable iff (!presetn) // R4
        fault_event_flag[0] && !ack[0] |=> fault_event_flag[0])
        else $error("flag cleared without acknowledge");
    a_ack_zero: assert property (@(posedge pclk) disable iff (!presetn) // R5
        rd && !penable && paddr == MPWM_FACK_OFS |=> prdata[3:0] == 4'h0)
        else $error("acknowledge bits read nonzero");
    a_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // R21
        ack[1] && fs2[1] && !fs3[1] |=> fault_event_flag[1])
        else $error("new fault lost to acknowledge");
    a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn) // R19
        fault_event_flag[1] && !fault_irq_enable[1]
        && (fault_event_flag & fault_irq_enable & 4'hD) == 4'h0 |-> !fault_irq_req)
        else $error("masked fault raised interrupt");
    a_manual_path: assert property (@(posedge pclk) disable iff (!presetn) // R8
        manual_override_enable && disabled == 6'h00 && indep
        ##1 manual_override_enable && $stable(manual_pin_values)
        |-> pwm_out[0] == $past(manual_pin_values[0]))
        else $error("manual bit not on output");
    a_gen_runs: assert property (@(posedge pclk) disable iff (!presetn) // R9
        run && manual_override_enable && !count_down && cnt < act_mod - 1'b1
        |=> cnt == $past(cnt) + 1'b1)
        else $error("counter stopped under manual control");
    a_fault_off: assert property (@(posedge pclk) disable iff (!presetn) // R18
        disabled[0] |=> !pwm_out[0])
        else $error("mapped output not disabled");
    a_load_boundary: assert property (@(posedge pclk) disable iff (!presetn) // R16
        !period_end |=> act_mod == $past(act_mod))
        else $error("modulus loaded off a boundary");
endmodule

/* bench/mpwm_power_stage.sv */
`timescale 1ns/100ps
module mpwm_power_stage (
    // Clock
    input  wire logic       pclk,
    // Bench commands
    input  wire logic [3:0] fault_cmd,
    input  wire logic [2:0] sense_cmd,
    // Pins towards the block
    output logic [3:0]      fault_in,
    output logic [2:0]      current_sense_in
);
    // Comparators settle one cycle after the bench asks, like a real sense path
    always_ff @(posedge pclk) begin
        fault_in         <= fault_cmd;
        current_sense_in <= sense_cmd;
    end
endmodule

/* bench/motor_pwm_fault_status_and_manual_output_tb.sv */
`timescale 1ns/100ps
module motor_pwm_fault_status_and_manual_output_tb;
    import mpwm_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  fault_in;
    logic [3:0]  fault_cmd;
    logic [2:0]  current_sense_in;
    logic [2:0]  sense_cmd;
    logic [5:0]  pwm_out;
    logic        fault_irq_req;
    logic [31:0] rd;
    logic        er;
    int          err_total;
    int          num_checks;

    mpwm_fault_out uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fault_in(fault_in), .current_sense_in(current_sense_in),
        .pwm_out(pwm_out), .fault_irq_req(fault_irq_req));
    mpwm_power_stage stage (.pclk(pclk), .fault_cmd(fault_cmd), .sense_cmd(sense_cmd),
        .fault_in(fault_in), .current_sense_in(current_sense_in));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Idle edge at the end keeps psel from being set twice in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a stalled access
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic edge_up(output int n);
        n = 0;
        while (pwm_out[0] !== 1'b0 && n < 1200) begin
            @(posedge pclk);
            n++;
        end
        while (pwm_out[0] !== 1'b1 && n < 1200) begin
            @(posedge pclk);
            n++;
        end
    endtask

    task automatic t_reset;
        rchk(MPWM_FSTATUS_OFS, 32'h0);
        rchk(MPWM_FACK_OFS, 32'h0);
        rchk(MPWM_MANUAL_OFS, 32'h0);
        // Stopped generator leaves complementary legs on
        chk({26'h0, pwm_out}, 32'h2A);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, MPWM_DEADTIME_OFS, 32'h2);
        apb(1'b1, MPWM_DISABLE_PIN_MAP_OFS, 32'h15);
        apb(1'b1, MPWM_FCTRL_OFS, 32'hF);
    endtask

    task automatic t_fault;
        for (int i = 0; i < 4; i++) begin
            fault_cmd <= 4'(1 << i);
            repeat (5) @(posedge pclk);
            chk({31'h0, fault_irq_req}, 32'h1);
            apb(1'b1, MPWM_FSTATUS_OFS, 32'h0);
            apb(1'b1, MPWM_FACK_OFS, ~(32'h1 << i) & 32'hF);
            rchk(MPWM_FSTATUS_OFS, 32'h11 << i);
            apb(1'b1, MPWM_FACK_OFS, 32'h1 << i);
            rchk(MPWM_FSTATUS_OFS, 32'h10 << i);
            fault_cmd <= 4'h0;
            repeat (4) @(posedge pclk);
            rchk(MPWM_FSTATUS_OFS, 32'h0);
        end
    endtask

    // Interrupt masked, yet mapped outputs must still drop
    task automatic t_disable;
        apb(1'b1, MPWM_FCTRL_OFS, 32'h0);
        apb(1'b1, MPWM_CTRL_OFS, 32'h4);
        apb(1'b1, MPWM_MANUAL_OFS, 32'hBF);
        repeat (4) @(posedge pclk);
        chk({26'h0, pwm_out}, 32'h3F);
        // Acknowledge lands on the edge-detect cycle; the new fault must survive
        fault_cmd <= 4'h2;
        repeat (2) @(posedge pclk);
        apb(1'b1, MPWM_FACK_OFS, 32'h2);
        repeat (2) @(posedge pclk);
        chk({31'h0, fault_irq_req}, 32'h0);
        chk({26'h0, pwm_out}, 32'h2A);
        apb(1'b1, MPWM_FCTRL_OFS, 32'hF);
        chk({31'h0, fault_irq_req}, 32'h1);
        fault_cmd <= 4'h0;
        repeat (4) @(posedge pclk);
        apb(1'b1, MPWM_FACK_OFS, 32'h2);
        repeat (4) @(posedge pclk);
        chk({26'h0, pwm_out}, 32'h3F);
    endtask

    task automatic t_manual;
        logic [5:0] p;
        logic [5:0] e;
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, MPWM_CTRL_OFS, m ? 32'h4 : 32'h0);
            for (int k = 0; k < 64; k++) begin
                p = 6'(k);
                apb(1'b1, MPWM_MANUAL_OFS, 32'h80 | 32'(p));
                repeat (6) @(posedge pclk);
                e = {p[5] & ~p[4], p[4], p[3] & ~p[2], p[2], p[1] & ~p[0], p[0]};
                chk({26'h0, pwm_out}, {26'h0, m ? p : e});
            end
        end
    endtask

    // Each leg's sense level is set before its leg turns on
    task automatic t_sense;
        apb(1'b1, MPWM_CTRL_OFS, 32'h0);
        apb(1'b1, MPWM_MANUAL_OFS, 32'h80);
        sense_cmd <= 3'b101;
        repeat (6) @(posedge pclk);
        apb(1'b1, MPWM_MANUAL_OFS, 32'h95);
        repeat (6) @(posedge pclk);
        sense_cmd <= 3'b010;
        apb(1'b1, MPWM_MANUAL_OFS, 32'h80);
        repeat (6) @(posedge pclk);
        apb(1'b1, MPWM_MANUAL_OFS, 32'hAA);
        repeat (6) @(posedge pclk);
        rchk(MPWM_FACK_OFS, 32'h190);
    endtask

    task automatic t_gen;
        int n;
        apb(1'b1, MPWM_MANUAL_OFS, 32'h0);
        apb(1'b1, MPWM_MODULUS_OFS, 32'h8);
        apb(1'b1, MPWM_DUTY1_OFS, 32'h4);
        apb(1'b1, MPWM_CTRL_OFS, 32'hD);
        repeat (3) edge_up(n);
        edge_up(n);
        chk(32'(n), 32'h8);
        apb(1'b1, MPWM_CTRL_OFS, 32'hF);
        repeat (3) edge_up(n);
        edge_up(n);
        chk(32'(n), 32'h10);
        apb(1'b1, MPWM_MANUAL_OFS, 32'h80);
        repeat (40) @(posedge pclk);
        chk({26'h0, pwm_out}, 32'h0);
        apb(1'b1, MPWM_MANUAL_OFS, 32'h0);
        edge_up(n);
        chk(32'(n <= 16), 32'h1);
    endtask

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Whole sequence needs well under a tenth of this
    initial begin
        repeat (100000) @(posedge pclk);
        err_total++;
        report_and_stop();
    end

    initial begin
        err_total = 0;
        num_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fault_cmd = 4'h0;
        sense_cmd = 3'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_fault();
        t_disable();
        t_manual();
        t_sense();
        t_gen();
        report_and_stop();
    end
endmodule
